// ===== vector_priority_map.vh
// Purpose: constants for the interrupt vector and priority resolver
// Assumes: register indices are local choices; vectors and fields are fixed
// Notes: register indices, reset value, field positions, fixed levels and vector bases live here
`ifndef VECTOR_PRIORITY_MAP_VH
`define VECTOR_PRIORITY_MAP_VH

// ----------------------------------------
// register indices (word address = index)
// ----------------------------------------
`define REG_PIN_LOW 3'h0
`define REG_PIN_HIGH 3'h1
`define REG_PIN_GROUP_CONV 3'h2
`define REG_TIMER_CH0_CH1 3'h3
`define REG_TIMER_CH1_CH2 3'h4
`define REG_STATUS 3'h5
`define REG_CORE_MASK 3'h6

// ----------------------------------------
// reset values and field layout
// ----------------------------------------
`define LEVEL_RESET 16'h0000
`define FIELD_HI 15
`define FIELD_MH 11
`define FIELD_ML 7
`define FIELD_LO 3

// ----------------------------------------
// fixed levels and vectors
// ----------------------------------------
`define LEVEL_NMI 5'h10
`define LEVEL_FIXED 5'h0F
`define VEC_NMI 8'h0B
`define VEC_BREAK 8'h0C
`define VEC_DEBUG 8'h0E
`define VEC_PIN_BASE 8'h40
`define VEC_LEVEL_PIN_BASE 8'h50
`define VEC_CONVERTER 8'h5C
`define VEC_T0_CMP_BASE 8'h6C
`define VEC_T0_OVF_BASE 8'h70
`define VEC_T1_CMP_BASE 8'h74
`define VEC_T1_OVF_BASE 8'h78
`define VEC_T2_CMP_BASE 8'h7C
`define VEC_T2_OVF_BASE 8'h80
`define NUM_SOURCES 31

`endif

// ===== interrupt_vector_priority_resolver.v
// Purpose: resolve pending interrupt sources to one vector and level
// Assumes: requests are levels synchronous to sys_clk_in, held until served
// Notes: answer registered one cycle after the pending inputs
//
// What this block does
// - each source has its own vector number and table offset
// - table offset is vector number times four
// - pins, pin group and peripheral groups take 4-bit levels 0 to 15
// - sources sharing one field use a fixed internal ranking, rank 1 highest
// - reset clears every programmable level to 0
// - equal levels resolved by fixed default order, nmi highest
// - nmi vector 11 level 16; break 12 and debug 14 at level 15
// - request pins 0-3 vectors 64-67, levels from low pin register
// - request pins 4-7 vectors 68-71, levels from high pin register
// - level pin interrupts 0-7 vectors 80-87 share bits 15:12
// - converter done vector 92, level bits 7:4
// - timer0 compare a-d vectors 108-111, bits 11:8 second register
// - timer0 overflow, e, f vectors 112-114, bits 7:4
// - timer1 compare 116-117 bits 3:0; overflow/underflow 120-121 bits 15:12
// - timer2 compare a,b vectors 124-125, bits 11:8 third register
// - timer2 overflow/underflow vectors 128-129, bits 7:4
// - a source at level 0 is never presented
`timescale 1ns/1ps
`default_nettype none
`include "vector_priority_map.vh"

module interrupt_vector_priority_resolver #(
    parameter LEVEL_WIDTH = 4
) (
    // clock and reset
    input wire sys_clk_in,
    input wire nrst_in,
    // register port
    input wire [2:0] reg_addr_in,
    input wire [15:0] reg_wdata_in,
    input wire reg_write_in,
    input wire reg_read_in,
    output reg [15:0] reg_rdata_out,
    // request sources
    input wire nmi_in,
    input wire break_in,
    input wire debug_interface_interrupt_in,
    input wire [7:0] request_pin_in,
    input wire [7:0] level_pin_interrupt_in,
    input wire converter_done_interrupt_in,
    input wire [3:0] timer0_compare_in,
    input wire [2:0] timer0_overflow_in,
    input wire [1:0] timer1_compare_in,
    input wire [1:0] timer1_underflow_in,
    input wire [1:0] timer2_compare_in,
    input wire [1:0] timer2_underflow_in,
    // core side
    input wire [3:0] core_mask_level_in,
    output reg irq_request_out,
    output reg [7:0] irq_vector_out,
    output reg [4:0] irq_level_out,
    output reg [9:0] irq_table_offset_out
);

// ----------------------------------------
// priority registers
// ----------------------------------------
reg [15:0] pin_priority_levels_low;
reg [15:0] pin_priority_levels_high;
reg [15:0] pin_group_converter_levels;
reg [15:0] timer_ch0_ch1_levels;
reg [15:0] timer_ch1_ch2_levels;

always @(posedge sys_clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
        pin_priority_levels_low <= `LEVEL_RESET;
        pin_priority_levels_high <= `LEVEL_RESET;
        pin_group_converter_levels <= `LEVEL_RESET;
        timer_ch0_ch1_levels <= `LEVEL_RESET;
        timer_ch1_ch2_levels <= `LEVEL_RESET;
    end else if (reg_write_in) begin
        case (reg_addr_in)
            `REG_PIN_LOW: pin_priority_levels_low <= reg_wdata_in;
            `REG_PIN_HIGH: pin_priority_levels_high <= reg_wdata_in;
            `REG_PIN_GROUP_CONV: pin_group_converter_levels <= reg_wdata_in;
            `REG_TIMER_CH0_CH1: timer_ch0_ch1_levels <= reg_wdata_in;
            `REG_TIMER_CH1_CH2: timer_ch1_ch2_levels <= reg_wdata_in;
            default: ;
        endcase
    end
end

// ----------------------------------------
// level fields
// ----------------------------------------
wire [LEVEL_WIDTH:0] pin_lvl [0:7];
wire [LEVEL_WIDTH:0] lpin_lvl;
wire [LEVEL_WIDTH:0] conv_lvl;
wire [LEVEL_WIDTH:0] t0_cmp_lvl;
wire [LEVEL_WIDTH:0] t0_ovf_lvl;
wire [LEVEL_WIDTH:0] t1_cmp_lvl;
wire [LEVEL_WIDTH:0] t1_ovf_lvl;
wire [LEVEL_WIDTH:0] t2_cmp_lvl;
wire [LEVEL_WIDTH:0] t2_ovf_lvl;

level_field_pick #(
    .LEVEL_WIDTH(LEVEL_WIDTH),
    .FIELD_MSB(`FIELD_HI)
) i_level_field_pick_pin0 (
    .word_in(pin_priority_levels_low),
    .level_out(pin_lvl[0])
);

level_field_pick #(
    .LEVEL_WIDTH(LEVEL_WIDTH),
    .FIELD_MSB(`FIELD_MH)
) i_level_field_pick_pin1 (
    .word_in(pin_priority_levels_low),
    .level_out(pin_lvl[1])
);

level_field_pick #(
    .LEVEL_WIDTH(LEVEL_WIDTH),
    .FIELD_MSB(`FIELD_ML)
) i_level_field_pick_pin2 (
    .word_in(pin_priority_levels_low),
    .level_out(pin_lvl[2])
);

level_field_pick #(
    .LEVEL_WIDTH(LEVEL_WIDTH),
    .FIELD_MSB(`FIELD_LO)
) i_level_field_pick_pin3 (
    .word_in(pin_priority_levels_low),
    .level_out(pin_lvl[3])
);

level_field_pick #(
    .LEVEL_WIDTH(LEVEL_WIDTH),
    .FIELD_MSB(`FIELD_HI)
) i_level_field_pick_pin4 (
    .word_in(pin_priority_levels_high),
    .level_out(pin_lvl[4])
);

level_field_pick #(
    .LEVEL_WIDTH(LEVEL_WIDTH),
    .FIELD_MSB(`FIELD_MH)
) i_level_field_pick_pin5 (
    .word_in(pin_priority_levels_high),
    .level_out(pin_lvl[5])
);

level_field_pick #(
    .LEVEL_WIDTH(LEVEL_WIDTH),
    .FIELD_MSB(`FIELD_ML)
) i_level_field_pick_pin6 (
    .word_in(pin_priority_levels_high),
    .level_out(pin_lvl[6])
);

level_field_pick #(
    .LEVEL_WIDTH(LEVEL_WIDTH),
    .FIELD_MSB(`FIELD_LO)
) i_level_field_pick_pin7 (
    .word_in(pin_priority_levels_high),
    .level_out(pin_lvl[7])
);

level_field_pick #(
    .LEVEL_WIDTH(LEVEL_WIDTH),
    .FIELD_MSB(`FIELD_HI)
) i_level_field_pick_lpin (
    .word_in(pin_group_converter_levels),
    .level_out(lpin_lvl)
);

level_field_pick #(
    .LEVEL_WIDTH(LEVEL_WIDTH),
    .FIELD_MSB(`FIELD_ML)
) i_level_field_pick_conv (
    .word_in(pin_group_converter_levels),
    .level_out(conv_lvl)
);

level_field_pick #(
    .LEVEL_WIDTH(LEVEL_WIDTH),
    .FIELD_MSB(`FIELD_MH)
) i_level_field_pick_t0_cmp (
    .word_in(timer_ch0_ch1_levels),
    .level_out(t0_cmp_lvl)
);

level_field_pick #(
    .LEVEL_WIDTH(LEVEL_WIDTH),
    .FIELD_MSB(`FIELD_ML)
) i_level_field_pick_t0_ovf (
    .word_in(timer_ch0_ch1_levels),
    .level_out(t0_ovf_lvl)
);

level_field_pick #(
    .LEVEL_WIDTH(LEVEL_WIDTH),
    .FIELD_MSB(`FIELD_LO)
) i_level_field_pick_t1_cmp (
    .word_in(timer_ch0_ch1_levels),
    .level_out(t1_cmp_lvl)
);

level_field_pick #(
    .LEVEL_WIDTH(LEVEL_WIDTH),
    .FIELD_MSB(`FIELD_HI)
) i_level_field_pick_t1_ovf (
    .word_in(timer_ch1_ch2_levels),
    .level_out(t1_ovf_lvl)
);

level_field_pick #(
    .LEVEL_WIDTH(LEVEL_WIDTH),
    .FIELD_MSB(`FIELD_MH)
) i_level_field_pick_t2_cmp (
    .word_in(timer_ch1_ch2_levels),
    .level_out(t2_cmp_lvl)
);

level_field_pick #(
    .LEVEL_WIDTH(LEVEL_WIDTH),
    .FIELD_MSB(`FIELD_ML)
) i_level_field_pick_t2_ovf (
    .word_in(timer_ch1_ch2_levels),
    .level_out(t2_ovf_lvl)
);

// ----------------------------------------
// source table in default order
// ----------------------------------------
// index 0 is highest; within a shared field, lower index is higher rank
reg [`NUM_SOURCES-1:0] pend;
reg [4:0] lvl [0:`NUM_SOURCES-1];
reg [7:0] vec [0:`NUM_SOURCES-1];
integer i;

always @* begin
    pend = {timer1_underflow_in[1], timer1_underflow_in[0],
            timer1_compare_in[1], timer1_compare_in[0],
            timer0_overflow_in[2], timer0_overflow_in[1], timer0_overflow_in[0],
            timer0_compare_in[3], timer0_compare_in[2],
            timer0_compare_in[1], timer0_compare_in[0],
            converter_done_interrupt_in,
            level_pin_interrupt_in[7], level_pin_interrupt_in[6],
            level_pin_interrupt_in[5], level_pin_interrupt_in[4],
            level_pin_interrupt_in[3], level_pin_interrupt_in[2],
            level_pin_interrupt_in[1], level_pin_interrupt_in[0],
            request_pin_in[7], request_pin_in[6], request_pin_in[5],
            request_pin_in[4], request_pin_in[3], request_pin_in[2],
            request_pin_in[1], request_pin_in[0],
            debug_interface_interrupt_in, break_in, nmi_in};
    lvl[0] = `LEVEL_NMI;
    vec[0] = `VEC_NMI;
    lvl[1] = `LEVEL_FIXED;
    vec[1] = `VEC_BREAK;
    lvl[2] = `LEVEL_FIXED;
    vec[2] = `VEC_DEBUG;
    for (i = 0; i < 4; i = i + 1) begin
        lvl[3+i] = pin_lvl[i];
        vec[3+i] = `VEC_PIN_BASE + i[7:0];
        lvl[7+i] = pin_lvl[4+i];
        vec[7+i] = `VEC_PIN_BASE + 8'h04 + i[7:0];
    end
    for (i = 0; i < 8; i = i + 1) begin
        lvl[11+i] = lpin_lvl;
        vec[11+i] = `VEC_LEVEL_PIN_BASE + i[7:0];
    end
    lvl[19] = conv_lvl;
    vec[19] = `VEC_CONVERTER;
    for (i = 0; i < 4; i = i + 1) begin
        lvl[20+i] = t0_cmp_lvl;
        vec[20+i] = `VEC_T0_CMP_BASE + i[7:0];
    end
    for (i = 0; i < 3; i = i + 1) begin
        lvl[24+i] = t0_ovf_lvl;
        vec[24+i] = `VEC_T0_OVF_BASE + i[7:0];
    end
    for (i = 0; i < 2; i = i + 1) begin
        lvl[27+i] = t1_cmp_lvl;
        vec[27+i] = `VEC_T1_CMP_BASE + i[7:0];
        lvl[29+i] = t1_ovf_lvl;
        vec[29+i] = `VEC_T1_OVF_BASE + i[7:0];
    end
end

// ----------------------------------------
// resolution
// ----------------------------------------
reg [4:0] best_lvl;
reg [7:0] best_vec;
reg found;
integer j;

always @* begin
    best_lvl = 5'h00;
    best_vec = 8'h00;
    found = 1'b0;
    // strict greater keeps earlier (higher default/rank) on ties
    for (j = 0; j < `NUM_SOURCES; j = j + 1) begin
        if (pend[j] && lvl[j] != 5'h00 && lvl[j] > best_lvl) begin
            best_lvl = lvl[j];
            best_vec = vec[j];
            found = 1'b1;
        end
    end
    // timer2 sources sit past the 31-entry core table
    for (j = 0; j < 2; j = j + 1) begin
        if (timer2_compare_in[j] && t2_cmp_lvl != 5'h00 && t2_cmp_lvl > best_lvl) begin
            best_lvl = t2_cmp_lvl;
            best_vec = `VEC_T2_CMP_BASE + j[7:0];
            found = 1'b1;
        end
    end
    for (j = 0; j < 2; j = j + 1) begin
        if (timer2_underflow_in[j] && t2_ovf_lvl != 5'h00 && t2_ovf_lvl > best_lvl) begin
            best_lvl = t2_ovf_lvl;
            best_vec = `VEC_T2_OVF_BASE + j[7:0];
            found = 1'b1;
        end
    end
end

// nmi always beats mask; others must exceed it
wire present = found && (best_lvl > {1'b0, core_mask_level_in});

always @(posedge sys_clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
        irq_request_out <= 1'b0;
        irq_vector_out <= 8'h00;
        irq_level_out <= 5'h00;
        irq_table_offset_out <= 10'h000;
    end else begin
        irq_request_out <= present;
        irq_vector_out <= present ? best_vec : 8'h00;
        irq_level_out <= present ? best_lvl : 5'h00;
        irq_table_offset_out <= present ? {best_vec, 2'b00} : 10'h000;
    end
end

// ----------------------------------------
// register read
// ----------------------------------------
always @(posedge sys_clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
        reg_rdata_out <= 16'h0000;
    end else if (reg_read_in) begin
        case (reg_addr_in)
            `REG_PIN_LOW: reg_rdata_out <= pin_priority_levels_low;
            `REG_PIN_HIGH: reg_rdata_out <= pin_priority_levels_high;
            `REG_PIN_GROUP_CONV: reg_rdata_out <= pin_group_converter_levels;
            `REG_TIMER_CH0_CH1: reg_rdata_out <= timer_ch0_ch1_levels;
            `REG_TIMER_CH1_CH2: reg_rdata_out <= timer_ch1_ch2_levels;
            `REG_STATUS: reg_rdata_out <= {irq_request_out, 2'b00, irq_level_out, irq_vector_out};
            `REG_CORE_MASK: reg_rdata_out <= {12'h000, core_mask_level_in};
            default: reg_rdata_out <= 16'h0000;
        endcase
    end else begin
        reg_rdata_out <= 16'h0000;
    end
end

endmodule

// ----------------------------------------
// one level field, widened by a zero top bit
// ----------------------------------------
module level_field_pick #(
    parameter LEVEL_WIDTH = 4,
    parameter FIELD_MSB = 15
) (
    // register word
    input wire [15:0] word_in,
    // widened level
    output wire [LEVEL_WIDTH:0] level_out
);

assign level_out = {1'b0, word_in[FIELD_MSB -: LEVEL_WIDTH]};

endmodule

`default_nettype wire

// ===== resolver_sva.sv
// Purpose: port checks of the vector priority resolver
// Assumes: answers registered one cycle after the inputs
// Notes: bound to the resolver top
`timescale 1ns/1ps
`default_nettype none
`include "vector_priority_map.vh"
module resolver_sva (
    // clock and reset
    input wire logic sys_clk_in,
    input wire logic nrst_in,
    // register port
    input wire logic [2:0] reg_addr_in,
    input wire logic [15:0] reg_wdata_in,
    input wire logic reg_write_in,
    input wire logic reg_read_in,
    input wire logic [15:0] reg_rdata_out,
    // sources and core side
    input wire logic nmi_in,
    input wire logic break_in,
    input wire logic debug_interface_interrupt_in,
    input wire logic [7:0] request_pin_in,
    input wire logic [3:0] core_mask_level_in,
    input wire logic irq_request_out,
    input wire logic [7:0] irq_vector_out,
    input wire logic [4:0] irq_level_out,
    input wire logic [9:0] irq_table_offset_out
);
    default clocking cb @(posedge sys_clk_in); endclocking
    default disable iff (!nrst_in);
    sequence s_quiet;
        !nmi_in && !break_in && !debug_interface_interrupt_in;
    endsequence
    sequence s_pin0_top;
        reg_write_in && reg_addr_in == `REG_PIN_LOW && reg_wdata_in[15:12] == 4'hF;
    endsequence
    property p_nmi;
        nmi_in |=> irq_request_out && irq_vector_out == `VEC_NMI && irq_level_out == `LEVEL_NMI;
    endproperty
    a_nmi: assert property (p_nmi) else $error("nmi not presented");
    property p_fixed;
        break_in && !nmi_in && core_mask_level_in != 4'hF
            |=> irq_vector_out == `VEC_BREAK && irq_level_out == `LEVEL_FIXED;
    endproperty
    a_fixed: assert property (p_fixed) else $error("break not chosen");
    property p_offset;
        irq_table_offset_out == {irq_vector_out, 2'b00};
    endproperty
    a_offset: assert property (p_offset) else $error("table offset wrong");
    property p_above;
        irq_request_out |-> irq_level_out > {1'b0, $past(core_mask_level_in)};
    endproperty
    a_above: assert property (p_above) else $error("request not above mask");
    property p_zero;
        irq_request_out |-> irq_level_out != 5'h00;
    endproperty
    a_zero: assert property (p_zero) else $error("level zero presented");
    property p_cap;
        s_quiet ##0 core_mask_level_in == 4'hF |=> !irq_request_out;
    endproperty
    a_cap: assert property (p_cap) else $error("request through full mask");
    property p_pin0;
        s_pin0_top ##1 (s_quiet ##0 request_pin_in[0] && core_mask_level_in != 4'hF)
            |=> irq_vector_out == `VEC_PIN_BASE && irq_level_out == 5'h0F;
    endproperty
    a_pin0: assert property (p_pin0) else $error("pin 0 level not applied");
    property p_readback;
        reg_write_in && reg_addr_in < 3'h5 ##1 reg_read_in && reg_addr_in == $past(reg_addr_in)
            |=> reg_rdata_out == $past(reg_wdata_in, 2);
    endproperty
    a_readback: assert property (p_readback) else $error("level register lost");
endmodule
bind interrupt_vector_priority_resolver resolver_sva i_resolver_sva (
    .sys_clk_in(sys_clk_in), .nrst_in(nrst_in), .reg_addr_in(reg_addr_in),
    .reg_wdata_in(reg_wdata_in), .reg_write_in(reg_write_in), .reg_read_in(reg_read_in),
    .reg_rdata_out(reg_rdata_out), .nmi_in(nmi_in), .break_in(break_in),
    .debug_interface_interrupt_in(debug_interface_interrupt_in),
    .request_pin_in(request_pin_in), .core_mask_level_in(core_mask_level_in),
    .irq_request_out(irq_request_out), .irq_vector_out(irq_vector_out),
    .irq_level_out(irq_level_out), .irq_table_offset_out(irq_table_offset_out));
`default_nettype wire

// ===== core_model.sv
// Purpose: core taking requests and raising its mask
// Assumes: bench says when a request is accepted
// Notes: fetch address is the accepted table entry
`timescale 1ns/1ps
`default_nettype none
module core_model (
    // clock and reset
    input wire logic sys_clk_in,
    input wire logic nrst_in,
    // bench control
    input wire logic accept_in,
    input wire logic load_in,
    input wire logic [3:0] load_level_in,
    // resolver side
    input wire logic irq_request_in,
    input wire logic [7:0] irq_vector_in,
    input wire logic [4:0] irq_level_in,
    output logic [3:0] mask_out,
    output logic [9:0] fetch_addr_out
);
    always @(posedge sys_clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            mask_out <= 4'h0;
            fetch_addr_out <= 10'h000;
        end else if (load_in) begin
            mask_out <= load_level_in;
        end else if (accept_in && irq_request_in) begin
            mask_out <= (irq_level_in > 5'h0F) ? 4'hF : irq_level_in[3:0];
            fetch_addr_out <= {irq_vector_in, 2'b00};
        end
    end
endmodule
`default_nettype wire

// ===== tb_interrupt_vector_priority_resolver.sv
// Purpose: register and priority tests of the resolver
// Assumes: sources are held levels
// Notes: table steps raise one group above the last
`timescale 1ns/1ps
`default_nettype none
`include "vector_priority_map.vh"
module tb_interrupt_vector_priority_resolver;
    logic sys_clk_in = 1'b0, nrst_in = 1'b0, reg_write_in = 1'b0, reg_read_in = 1'b0;
    logic nmi_in = 1'b0, break_in = 1'b0, dbg = 1'b0, accept = 1'b0, load = 1'b0;
    logic [2:0] reg_addr_in = 3'h0;
    logic [15:0] reg_wdata_in = 16'h0000, periph = 16'h0000;
    logic [7:0] pins = 8'h00, lpins = 8'h00;
    logic [3:0] load_lvl = 4'h0;
    wire [3:0] mask;
    wire [15:0] rdata;
    wire irq;
    wire [7:0] vec;
    wire [4:0] lvl;
    wire [9:0] off, fetch;
    int fail_count = 0, n_checks = 0, i;
    logic [31:0] e;
    logic [31:0] tbl [12] = '{32'h40010801, 32'h402107C2, 32'h43210783, 32'h30004744,
        32'h30054705, 32'h306546C6, 32'h200705C7, 32'h28070508, 32'h10009479,
        32'h1C00944C, 32'h0000D43D, 32'h0F00D40F};
    always #12.5 sys_clk_in = ~sys_clk_in;
    interrupt_vector_priority_resolver i_interrupt_vector_priority_resolver (
        .sys_clk_in(sys_clk_in), .nrst_in(nrst_in), .reg_addr_in(reg_addr_in),
        .reg_wdata_in(reg_wdata_in), .reg_write_in(reg_write_in), .reg_read_in(reg_read_in),
        .reg_rdata_out(rdata), .nmi_in(nmi_in), .break_in(break_in),
        .debug_interface_interrupt_in(dbg), .request_pin_in(pins),
        .level_pin_interrupt_in(lpins), .converter_done_interrupt_in(periph[15]),
        .timer0_compare_in(periph[14:11]), .timer0_overflow_in(periph[10:8]),
        .timer1_compare_in(periph[7:6]), .timer1_underflow_in(periph[5:4]),
        .timer2_compare_in(periph[3:2]), .timer2_underflow_in(periph[1:0]),
        .core_mask_level_in(mask), .irq_request_out(irq), .irq_vector_out(vec),
        .irq_level_out(lvl), .irq_table_offset_out(off));
    core_model i_core_model (.sys_clk_in(sys_clk_in), .nrst_in(nrst_in), .accept_in(accept),
        .load_in(load), .load_level_in(load_lvl), .irq_request_in(irq), .irq_vector_in(vec),
        .irq_level_in(lvl), .mask_out(mask), .fetch_addr_out(fetch));
    task automatic end_sim;
        $display("checks %0d mismatches %0d", n_checks, fail_count);
        if (fail_count == 0 && n_checks > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask
    task automatic chk(input logic [23:0] got, input logic [23:0] exp);
        n_checks++;
        if (got !== exp) begin
            fail_count++;
            $display("unexpected t=%0t got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic chk_irq(input logic [7:0] v, input logic [4:0] l);
        repeat (2) @(posedge sys_clk_in);
        #1 chk({irq, vec, lvl, off}, {l != 5'h00, v, l, v, 2'b00});
    endtask
    task automatic wr(input logic [2:0] a, input logic [15:0] d);
        @(posedge sys_clk_in);
        reg_write_in <= 1'b1;
        reg_read_in <= 1'b0;
        reg_addr_in <= a;
        reg_wdata_in <= d;
    endtask
    task automatic rd(input logic [2:0] a, input logic [15:0] d);
        @(posedge sys_clk_in);
        reg_write_in <= 1'b0;
        reg_read_in <= 1'b1;
        reg_addr_in <= a;
        @(posedge sys_clk_in);
        reg_read_in <= 1'b0;
        #1 chk({8'h00, rdata}, {8'h00, d});
    endtask
    task automatic pulse_accept;
        @(posedge sys_clk_in);
        accept <= 1'b1;
        @(posedge sys_clk_in);
        accept <= 1'b0;
        #1;
    endtask
    initial begin
        repeat (5000) @(posedge sys_clk_in);
        fail_count++;
        end_sim();
    end
    initial begin
        repeat (3) @(posedge sys_clk_in);
        nrst_in <= 1'b1;
        for (i = 0; i < 8; i++) rd(i[2:0], 16'h0000);
        @(posedge sys_clk_in);
        {periph, pins, lpins} <= 32'hFFFFFFFF;
        chk_irq(8'h00, 5'h00);
        $display("test reset levels done");
        for (i = 0; i < 12; i++) begin
            e = tbl[i];
            wr(e[30:28], e[27:12]);
            rd(e[30:28], e[27:12]);
            chk_irq(e[11:4], {1'b0, e[3:0]});
        end
        $display("test vector table done");
        wr(`REG_PIN_LOW, 16'hFFFF);
        rd(`REG_PIN_LOW, 16'hFFFF);
        wr(`REG_PIN_HIGH, 16'hFFFF);
        rd(`REG_PIN_HIGH, 16'hFFFF);
        @(posedge sys_clk_in);
        pins <= 8'hFE;
        chk_irq(8'h41, 5'h0F);
        dbg <= 1'b1;
        chk_irq(`VEC_DEBUG, `LEVEL_FIXED);
        break_in <= 1'b1;
        chk_irq(`VEC_BREAK, `LEVEL_FIXED);
        {nmi_in, break_in, dbg, pins, lpins} <= {11'h000, 8'h0C};
        chk_irq(8'h52, 5'h08);
        load <= 1'b1;
        load_lvl <= 4'h8;
        @(posedge sys_clk_in);
        load <= 1'b0;
        chk_irq(8'h00, 5'h00);
        load <= 1'b1;
        load_lvl <= 4'h7;
        @(posedge sys_clk_in);
        load <= 1'b0;
        chk_irq(8'h52, 5'h08);
        rd(`REG_STATUS, 16'h8852);
        rd(`REG_CORE_MASK, 16'h0007);
        pulse_accept();
        chk({10'h000, mask, fetch}, {10'h000, 4'h8, 10'h148});
        nmi_in <= 1'b1;
        chk_irq(`VEC_NMI, `LEVEL_NMI);
        pulse_accept();
        chk({10'h000, mask, fetch}, {10'h000, 4'hF, 10'h02C});
        @(posedge sys_clk_in);
        nmi_in <= 1'b0;
        chk_irq(8'h00, 5'h00);
        nrst_in <= 1'b0;
        repeat (2) @(posedge sys_clk_in);
        nrst_in <= 1'b1;
        rd(`REG_PIN_GROUP_CONV, 16'h0000);
        $display("test core side done");
        end_sim();
    end
endmodule
`default_nettype wire
